// ==== dv/utd_mem_model.sv ====
// main memory partner for the dma bus master
module utd_mem_model (
    input wire logic ref_clk, rst_n, mem_req, mem_we, slow,
    input wire logic [31:0] mem_addr, mem_wdata,
    output logic mem_ack,
    output logic [31:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [0:255];
    logic [1:0] wait_q;
    initial begin
        {mem_ack, mem_rdata, wait_q} = '0;
        for (int i = 0; i < 256; i++) mem[i] = 32'(i);
    end
    always @(posedge ref_clk) begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata; // an idle bus inverts the last word every cycle rather than holding it
        wait_q <= wait_q + 2'h1;
        if (mem_req && !mem_ack && rst_n && (!slow || wait_q == 2'h3)) begin
            mem_ack <= 1'b1;
            mem_rdata <= mem[mem_addr[9:2]];
            if (mem_we) mem[mem_addr[9:2]] <= mem_wdata;
        end
    end
endmodule // utd_mem_model

// ==== dv/utd_tx_dma_props.sv ====
// port checker for the transmit descriptor dma
module utd_tx_dma_props import utd_pkg::*; #(parameter int NCH = 4) (
    // apb and clock
    input wire logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    // memory, fifo, interrupts
    input wire logic mem_req, mem_we, mem_ack, fifo_valid, fifo_ready,
    input wire logic [31:0] mem_addr, mem_wdata, mem_rdata,
    input wire utd_beat_type fifo_beat,
    input wire logic [CH_FIELD_W-1:0] fifo_chan,
    input wire logic [NCH-1:0] tx_channel_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence apb_setup; psel && !penable; endsequence
    sequence beat_stall; fifo_valid && !fifo_ready; endsequence
    chk_apb_answer: assert property (apb_setup |-> ##2 pready)
        else $error("apb answer late");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready too long");
    chk_err_read: assert property (pslverr |-> pready && (pwrite || prdata == 32'h0))
        else $error("bad refused access");
    chk_mem_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable({mem_we, mem_addr, mem_wdata}))
        else $error("memory request moved");
    chk_mem_align: assert property (mem_req |-> mem_addr[1:0] == 2'h0)
        else $error("unaligned memory access");
    chk_beat_hold: assert property (beat_stall |=> fifo_valid && $stable({fifo_beat, fifo_chan}))
        else $error("beat moved while stalled");
    chk_zlp_shape: assert property (fifo_valid && fifo_beat.zlp |-> fifo_beat.last && fifo_beat.bytes == 3'h0)
        else $error("bad zero length beat");
    chk_beat_bytes: assert property (fifo_valid && !fifo_beat.zlp |-> fifo_beat.bytes inside {[1:4]} && fifo_chan < NCH)
        else $error("bad beat size");
    chk_irq_ack: assert property ($fell(tx_channel_irq[0]) |-> $past(pready && pwrite) || $past(pready && pwrite, 2))
        else $error("irq dropped without ack");
endmodule // utd_tx_dma_props
bind utd_tx_dma utd_tx_dma_props #(.NCH(NCH)) u_props (.*);

// ==== dv/utd_tx_dma_tb.sv ====
// self-checking bench for the transmit descriptor dma
module utd_tx_dma_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import utd_pkg::*;
    typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] e; logic r;} utd_row_type;
    logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, mem_req, mem_we, mem_ack;
    logic fifo_valid, fifo_ready, slow, err_q;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, mem_addr, mem_wdata, mem_rdata, rd;
    logic [CH_FIELD_W-1:0] fifo_chan;
    logic [3:0] tx_channel_irq;
    utd_beat_type fifo_beat;
    utd_beat_type beats[$];
    int err_count = 0;
    int compares = 0;
    int cyc = 0;
    utd_row_type rows[8] = '{'{1'b0, 12'h11c, 32'h0, 32'h40, 1'b0}, '{1'b0, 12'h118, 32'h0, 32'h0, 1'b0},
        '{1'b1, 12'h004, 32'h2, 32'h0, 1'b0}, '{1'b0, 12'h004, 32'h0, 32'h2, 1'b0},
        '{1'b1, 12'h00c, 32'h3, 32'h0, 1'b0}, '{1'b1, 12'h008, 32'h1, 32'h0, 1'b0},
        '{1'b0, 12'h008, 32'h0, 32'h1, 1'b0}, '{1'b0, 12'h0f0, 32'h0, 32'h0, 1'b1}};
    logic [31:0] dsc[15] = '{32'h60, 32'h70, 32'h6, 32'he0000006, 32'h0, 32'h0, 32'h0, 32'h0,
        32'h0, 32'h78, 32'h4, 32'he0000004, 32'h04030201, 32'h605, 32'h0a090807};
    logic [31:0] sg[4] = '{32'h0, 32'h200, 32'h80, 32'he0000080};
    logic [36:0] xb[3] = '{{32'h04030201, 5'h10}, {32'h605, 5'h0a}, {32'h0a090807, 5'h12}};
    utd_tx_dma #(.NCH(4)) DUT (.*);
    utd_mem_model u_mem (.*);
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        fifo_ready <= !(slow && cyc[1]); // far side stalls during the slow case
        if (fifo_valid && fifo_ready) beats.push_back(fifo_beat);
        if (cyc == 30000) begin
            err_count++;
            stop_test();
        end
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic poll(input logic [11:0] a, input logic [31:0] v);
        rd = ~v;
        for (int i = 0; i < 300 && rd !== v; i++) apb(1'b0, a, 32'h0);
    endtask
    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        {rst_n, psel, penable, pwrite, slow, paddr, pwdata} = '0;
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 12; i++) apb(1'b1, 12'(256 + 32 * (i / 6) + 4 * (i % 6)), 32'h0);
        chk(beats.size(), 0);
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) chk(rd, rows[i].e);
            chk(err_q, rows[i].r);
        end
        $display("register rows done");
        foreach (dsc[i]) u_mem.mem[16 + i] = dsc[i];
        foreach (sg[i]) u_mem.mem[64 + i] = sg[i];
        apb(1'b1, 12'h100, 32'h40);
        poll(12'h100, 32'h0);
        chk(rd, 32'h0);
        chk(beats.size(), 3);
        foreach (xb[i]) chk(beats[i] & {(i == 1) ? 32'hffff : 32'hffffffff, 5'h1f}, xb[i]);
        chk(u_mem.mem[19], 32'hc0000006);
        chk(u_mem.mem[27], 32'hd0000004);
        apb(1'b0, 12'h118, 32'h0);
        chk(rd, 32'h60);
        apb(1'b1, 12'h118, 32'h40);
        repeat (2) @(posedge ref_clk);
        chk(tx_channel_irq, 4'h1);
        apb(1'b1, 12'h118, 32'h60);
        repeat (2) @(posedge ref_clk);
        chk(tx_channel_irq, 4'h0);
        $display("transparent queue done");
        beats.delete();
        slow <= 1'b1;
        apb(1'b1, 12'h120, 32'h100);
        poll(12'h120, 32'h0);
        chk(beats.size(), 33);
        chk({beats[14].last, beats[15].last, beats[31].last, beats[32].zlp, beats[32].last}, 5'h0f);
        chk(u_mem.mem[67], 32'hd0000080);
        chk(tx_channel_irq, 4'h2);
        $display("segmenting packet done");
        beats.delete();
        u_mem.mem[16] = 32'h0;
        u_mem.mem[19] = 32'he0000006;
        u_mem.mem[24] = 32'h40;
        chk({u_mem.mem[27][29:28], u_mem.mem[24] != 32'h0}, 3'h3);
        apb(1'b1, 12'h100, 32'h40);
        poll(12'h100, 32'h0);
        chk(beats.size(), 2);
        chk(u_mem.mem[19], 32'hd0000006);
        chk(tx_channel_irq, 4'h3);
        $display("misqueue restart done");
        stop_test();
    end
endmodule // utd_tx_dma_tb

// ==== logic/utd_pkg.sv ====
// shared constants and types for the transmit descriptor dma
package utd_pkg;
    // ------------------------------------------------------------
    // register map, byte addresses
    // ------------------------------------------------------------
    localparam logic [3:0] REGION_GLOBAL = 4'h0;
    localparam logic [3:0] REGION_CHAN = 4'h1;
    localparam logic [4:0] OFS_GLOBAL_CONTROL = 5'h00;
    localparam logic [4:0] OFS_SEGMENT_MODE = 5'h04;
    localparam logic [4:0] OFS_TX_DMA_CONTROL = 5'h08;
    localparam logic [4:0] OFS_EP_DMA_ENABLE = 5'h0c;
    localparam logic [4:0] OFS_HEAD = 5'h00;
    localparam logic [4:0] OFS_FIRST = 5'h04;
    localparam logic [4:0] OFS_CURRENT = 5'h08;
    localparam logic [4:0] OFS_BUFFER = 5'h0c;
    localparam logic [4:0] OFS_LENGTH = 5'h14;
    localparam logic [4:0] OFS_COMPLETION = 5'h18;
    localparam logic [4:0] OFS_MAX_PACKET = 5'h1c;
    localparam int CH_FIELD_W = 3;
    localparam int SEG_MODE_BIT = 0;
    localparam int PORT_ENABLE_BIT = 0;
    localparam logic [15:0] MPS_RESET = 16'h0040;
    // ------------------------------------------------------------
    // descriptor layout
    // ------------------------------------------------------------
    localparam logic [31:0] DESC_STEP = 32'h0000_0004;
    localparam logic [31:0] DESC_W3_OFS = 32'h0000_000c;
    localparam logic [1:0] DESC_LAST_WORD = 2'h3;
    localparam logic [2:0] BYTES_PER_WORD = 3'h4;
    typedef struct packed {
        logic sop;
        logic eop;
        logic own;
        logic end_of_queue_flag;
        logic [3:0] rsv_hi;
        logic zero_byte;
        logic [6:0] rsv_lo;
        logic [15:0] pkt_len;
    } utd_w3_type;
    typedef struct packed {
        logic [31:0] data;
        logic [2:0] bytes;
        logic last;
        logic zlp;
    } utd_beat_type;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_FETCH = 3'b001,
        ST_DATA = 3'b011,
        ST_PUSH = 3'b010,
        ST_BUF_END = 3'b110,
        ST_WR_EOQ = 3'b111,
        ST_WR_OWN = 3'b101
    } utd_state_type;
endpackage

// ==== logic/utd_tx_dma.sv ====
// transmit descriptor dma engine with apb registers
// Functional notes
// - a nonzero head pointer write starts that channel's queue
// - each channel has one queue: one head pointer, one completion pointer
// - packets released from list head as each completes, until queue empty
// - on packet end clear ownership in first, write last address to completion
// - at queue end set end-of-queue, clear ownership, zero head, write completion
// - channel interrupt stays high while software and device completion values differ
// - transparent mode interrupts per dma packet; packets fit max size and fifo
// - segmenting mode splits dma packet into max-size usb packets, one interrupt
// - exact multiple ends with zero-length packet, otherwise final packet is short
// - global mode bit segments all channels, per-channel bit segments one
// - descriptor word 3 bit 29 is ownership, bit 28 is end-of-queue
module utd_tx_dma import utd_pkg::*; #(
    parameter int NCH = 4
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // memory bus master
    output logic mem_req,
    output logic mem_we,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    // endpoint transmit fifo
    output utd_beat_type fifo_beat,
    output logic fifo_valid,
    output logic [CH_FIELD_W-1:0] fifo_chan,
    input wire logic fifo_ready,
    // channel interrupts
    output logic [NCH-1:0] tx_channel_irq
);
    localparam int CW = $clog2(NCH);

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic seg_all_q;
    logic [NCH-1:0] channel_segment_enable_q;
    logic dma_port_enable_q;
    logic [NCH-1:0] endpoint_dma_enable_q;
    logic [31:0] head_q [NCH];
    logic [31:0] first_q [NCH];
    logic [31:0] cur_q [NCH];
    logic [31:0] bufp_q [NCH];
    logic [31:0] len_q [NCH];
    logic [31:0] comp_hw_q [NCH];
    logic [31:0] comp_sw_q [NCH];
    logic [15:0] mps_q [NCH];
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [NCH-1:0] irq_q;

    // ------------------------------------------------------------
    // engine state
    // ------------------------------------------------------------
    utd_state_type state_q;
    logic [CW-1:0] act_q;
    logic [1:0] widx_q;
    logic [31:0] next_q;
    logic [31:0] w1_q;
    logic [31:0] w2_q;
    utd_w3_type w3_q;
    utd_w3_type sop_w3_q;
    logic [15:0] blen_q;
    logic [15:0] usb_cnt_q;
    logic [2:0] nb_q;
    logic zlp_q;
    logic last_pkt_q;
    logic mem_req_q;
    logic mem_we_q;
    logic [31:0] mem_addr_q;
    logic [31:0] mem_wdata_q;
    utd_beat_type beat_q;
    logic fifo_valid_q;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire logic setup_done = psel & penable & ~pready_q;
    wire logic wr_en = psel & penable & pready_q & pwrite;
    wire logic glob_hit = paddr[11:8] == REGION_GLOBAL;
    wire logic [CH_FIELD_W-1:0] a_ch = paddr[7:5];
    wire logic chan_hit = (paddr[11:8] == REGION_CHAN) & (32'(a_ch) < NCH);
    wire logic [CW-1:0] a_idx = a_ch[CW-1:0];
    wire logic [4:0] a_reg = paddr[4:0];
    logic [31:0] rd_mux;
    logic rd_hit;

    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        if (glob_hit) begin
            unique case (a_reg)
                OFS_GLOBAL_CONTROL: rd_mux[SEG_MODE_BIT] = seg_all_q;
                OFS_SEGMENT_MODE: rd_mux[NCH-1:0] = channel_segment_enable_q;
                OFS_TX_DMA_CONTROL: rd_mux[PORT_ENABLE_BIT] = dma_port_enable_q;
                OFS_EP_DMA_ENABLE: rd_mux[NCH-1:0] = endpoint_dma_enable_q;
                default: rd_hit = 1'b0;
            endcase
        end else if (chan_hit) begin
            unique case (a_reg)
                OFS_HEAD: rd_mux = head_q[a_idx];
                OFS_FIRST: rd_mux = first_q[a_idx];
                OFS_CURRENT: rd_mux = cur_q[a_idx];
                OFS_BUFFER: rd_mux = bufp_q[a_idx];
                OFS_LENGTH: rd_mux = len_q[a_idx];
                OFS_COMPLETION: rd_mux = comp_hw_q[a_idx];
                OFS_MAX_PACKET: rd_mux[15:0] = mps_q[a_idx];
                default: rd_hit = 1'b0;
            endcase
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= setup_done;
            pslverr_q <= setup_done & ~rd_hit;
            prdata_q <= setup_done ? rd_mux : prdata_q;
        end
    end

    wire logic gwr = wr_en & glob_hit;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            seg_all_q <= 1'b0;
            channel_segment_enable_q <= '0;
            dma_port_enable_q <= 1'b0;
            endpoint_dma_enable_q <= '0;
        end else if (gwr) begin
            if (a_reg == OFS_GLOBAL_CONTROL) seg_all_q <= pwdata[SEG_MODE_BIT];
            if (a_reg == OFS_SEGMENT_MODE) channel_segment_enable_q <= pwdata[NCH-1:0];
            if (a_reg == OFS_TX_DMA_CONTROL) dma_port_enable_q <= pwdata[PORT_ENABLE_BIT];
            if (a_reg == OFS_EP_DMA_ENABLE) endpoint_dma_enable_q <= pwdata[NCH-1:0];
        end
    end

    // ------------------------------------------------------------
    // engine helpers
    // ------------------------------------------------------------
    wire logic mem_done = mem_req_q & mem_ack;
    wire logic push_done = fifo_valid_q & fifo_ready;
    wire utd_w3_type w3_in = utd_w3_type'(mem_rdata);
    wire logic fetch_end = (state_q == ST_FETCH) & mem_done & (widx_q == DESC_LAST_WORD);
    wire logic [15:0] pkt_rem = len_q[act_q][15:0];
    wire logic seg_on = seg_all_q | channel_segment_enable_q[act_q];
    wire logic [15:0] word_bytes = {13'h0000, BYTES_PER_WORD};
    wire logic [15:0] min_a = (blen_q < word_bytes) ? blen_q : word_bytes;
    wire logic [15:0] nb_w = (pkt_rem < min_a) ? pkt_rem : min_a;
    wire logic pkt_end = pkt_rem == nb_w;
    wire logic seg_full = (usb_cnt_q + nb_w) >= mps_q[act_q];
    wire logic [15:0] nb16 = {13'h0000, nb_q};
    wire logic pkt_over = (pkt_rem == 16'h0000) | w3_q.eop | (next_q == 32'h0000_0000);
    wire logic buf_over = (blen_q == nb16) | (pkt_rem == nb16);
    wire logic own_done = (state_q == ST_WR_OWN) & mem_done;
    wire logic advance = (state_q == ST_BUF_END) & ~pkt_over;
    // a zero-length beat carries no bytes, so only data beats move the buffer and length
    wire logic data_push = (state_q == ST_PUSH) & push_done & ~beat_q.zlp;
    wire logic [31:0] buf_start = w1_q + (w3_in.sop ? {16'h0000, w2_q[31:16]} : 32'h0000_0000);
    // sop bit alone picks the first descriptor; a single-buffer packet shares one word 3
    wire utd_w3_type own_clear = (first_q[act_q] == cur_q[act_q]) ?
        utd_w3_type'({w3_q.sop, w3_q.eop, 1'b0, last_pkt_q, w3_q[27:0]}) :
        utd_w3_type'({sop_w3_q.sop, sop_w3_q.eop, 1'b0, sop_w3_q[28:0]});
    logic [NCH-1:0] eligible;
    logic pick_ok;
    logic [CW-1:0] pick_ch;

    // ------------------------------------------------------------
    // per-channel state words
    // ------------------------------------------------------------
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        wire logic sel = act_q == CW'(c);
        wire logic cwr = wr_en & chan_hit & (a_idx == CW'(c));
        assign eligible[c] = (head_q[c] != 32'h0000_0000) & dma_port_enable_q & endpoint_dma_enable_q[c];
        always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
                head_q[c] <= 32'h0000_0000;
                first_q[c] <= 32'h0000_0000;
                cur_q[c] <= 32'h0000_0000;
                bufp_q[c] <= 32'h0000_0000;
                len_q[c] <= 32'h0000_0000;
                comp_hw_q[c] <= 32'h0000_0000;
                comp_sw_q[c] <= 32'h0000_0000;
                mps_q[c] <= MPS_RESET;
                irq_q[c] <= 1'b0;
            end else begin
                // a software head write wins so a misqueued packet can always be restarted
                if (cwr && a_reg == OFS_HEAD) head_q[c] <= pwdata;
                else if (sel && own_done) head_q[c] <= last_pkt_q ? 32'h0000_0000 : next_q;
                if (sel && fetch_end && w3_in.sop) first_q[c] <= cur_q[c];
                else if (cwr && a_reg == OFS_FIRST) first_q[c] <= pwdata;
                if (state_q == ST_IDLE && pick_ok && pick_ch == CW'(c)) cur_q[c] <= head_q[c];
                else if (sel && advance) cur_q[c] <= next_q;
                else if (cwr && a_reg == OFS_CURRENT) cur_q[c] <= pwdata;
                if (sel && fetch_end) bufp_q[c] <= buf_start;
                else if (sel && data_push) bufp_q[c] <= bufp_q[c] + {29'h0000_0000, nb_q};
                else if (cwr && a_reg == OFS_BUFFER) bufp_q[c] <= pwdata;
                if (sel && fetch_end && w3_in.sop) len_q[c] <= w3_in.zero_byte ? {w3_in.pkt_len, 16'h0000} :
                    {w3_in.pkt_len, w3_in.pkt_len};
                else if (sel && data_push) len_q[c][15:0] <= pkt_rem - nb16;
                else if (cwr && a_reg == OFS_LENGTH) len_q[c] <= pwdata;
                if (sel && own_done) comp_hw_q[c] <= cur_q[c];
                if (cwr && a_reg == OFS_COMPLETION) comp_sw_q[c] <= pwdata;
                if (cwr && a_reg == OFS_MAX_PACKET) mps_q[c] <= pwdata[15:0];
                // device update counts as the set: same-cycle acknowledge leaves the line high
                irq_q[c] <= (sel && own_done) ? 1'b1 : (comp_hw_q[c] != comp_sw_q[c]);
            end
        end
    end

    // rotating pick keeps one busy channel from starving the others; NCH must be a power of two
    always_comb begin
        pick_ok = 1'b0;
        pick_ch = act_q;
        for (int i = NCH; i >= 1; i--) begin
            if (eligible[act_q + CW'(i)]) begin
                pick_ok = 1'b1;
                pick_ch = act_q + CW'(i);
            end
        end
    end

    // ------------------------------------------------------------
    // descriptor walk and data engine
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            act_q <= '0;
            widx_q <= 2'h0;
            next_q <= 32'h0000_0000;
            w1_q <= 32'h0000_0000;
            w2_q <= 32'h0000_0000;
            w3_q <= '0;
            sop_w3_q <= '0;
            blen_q <= 16'h0000;
            usb_cnt_q <= 16'h0000;
            nb_q <= 3'h0;
            zlp_q <= 1'b0;
            last_pkt_q <= 1'b0;
            mem_req_q <= 1'b0;
            mem_we_q <= 1'b0;
            mem_addr_q <= 32'h0000_0000;
            mem_wdata_q <= 32'h0000_0000;
            beat_q <= '0;
            fifo_valid_q <= 1'b0;
        end else begin
            if (mem_done) mem_req_q <= 1'b0;
            unique case (state_q)
                ST_IDLE: begin
                    if (pick_ok) begin
                        act_q <= pick_ch;
                        widx_q <= 2'h0;
                        usb_cnt_q <= 16'h0000;
                        mem_req_q <= 1'b1;
                        mem_we_q <= 1'b0;
                        mem_addr_q <= head_q[pick_ch];
                        state_q <= ST_FETCH;
                    end
                end
                ST_FETCH: begin
                    if (mem_done) begin
                        widx_q <= widx_q + 2'h1;
                        if (widx_q == 2'h0) next_q <= mem_rdata;
                        if (widx_q == 2'h1) w1_q <= mem_rdata;
                        if (widx_q == 2'h2) w2_q <= mem_rdata;
                        if (widx_q != DESC_LAST_WORD) begin
                            mem_req_q <= 1'b1;
                            mem_addr_q <= mem_addr_q + DESC_STEP;
                        end else begin
                            w3_q <= w3_in;
                            blen_q <= w2_q[15:0];
                            if (w3_in.sop) sop_w3_q <= w3_in;
                            if (w3_in.sop && w3_in.zero_byte) begin
                                beat_q <= '{data: 32'h0000_0000, bytes: 3'h0, last: 1'b1, zlp: 1'b1};
                                fifo_valid_q <= 1'b1;
                                nb_q <= 3'h0;
                                state_q <= ST_PUSH;
                            end else if (w2_q[15:0] == 16'h0000) begin
                                state_q <= ST_BUF_END;
                            end else begin
                                mem_req_q <= 1'b1;
                                mem_addr_q <= buf_start;
                                state_q <= ST_DATA;
                            end
                        end
                    end
                end
                ST_DATA: begin
                    if (mem_done) begin
                        // buffers are word aligned; a segment edge that splits a word is not supported
                        beat_q.data <= mem_rdata;
                        beat_q.bytes <= nb_w[2:0];
                        beat_q.zlp <= 1'b0;
                        beat_q.last <= pkt_end | (seg_on & seg_full);
                        zlp_q <= seg_on & pkt_end & seg_full;
                        nb_q <= nb_w[2:0];
                        fifo_valid_q <= 1'b1;
                        state_q <= ST_PUSH;
                    end
                end
                ST_PUSH: begin
                    if (push_done) begin
                        if (zlp_q) begin
                            beat_q <= '{data: 32'h0000_0000, bytes: 3'h0, last: 1'b1, zlp: 1'b1};
                            blen_q <= blen_q - nb16;
                            zlp_q <= 1'b0;
                            nb_q <= 3'h0;
                        end else begin
                            fifo_valid_q <= 1'b0;
                            blen_q <= blen_q - nb16;
                            usb_cnt_q <= beat_q.last ? 16'h0000 : usb_cnt_q + nb16;
                            if (buf_over) begin
                                state_q <= ST_BUF_END;
                            end else begin
                                mem_req_q <= 1'b1;
                                mem_addr_q <= bufp_q[act_q] + {29'h0000_0000, nb_q};
                                state_q <= ST_DATA;
                            end
                        end
                    end
                end
                ST_BUF_END: begin
                    mem_req_q <= pkt_over;
                    mem_we_q <= pkt_over;
                    last_pkt_q <= next_q == 32'h0000_0000;
                    if (!pkt_over) begin
                        widx_q <= 2'h0;
                        mem_req_q <= 1'b1;
                        mem_addr_q <= next_q;
                        state_q <= ST_FETCH;
                    end else if (next_q == 32'h0000_0000) begin
                        mem_addr_q <= cur_q[act_q] + DESC_W3_OFS;
                        mem_wdata_q <= {w3_q.sop, w3_q.eop, w3_q.own, 1'b1, w3_q[27:0]};
                        state_q <= ST_WR_EOQ;
                    end else begin
                        mem_addr_q <= first_q[act_q] + DESC_W3_OFS;
                        mem_wdata_q <= {sop_w3_q.sop, sop_w3_q.eop, 1'b0, sop_w3_q[28:0]};
                        state_q <= ST_WR_OWN;
                    end
                end
                ST_WR_EOQ: begin
                    if (mem_done) begin
                        mem_req_q <= 1'b1;
                        mem_addr_q <= first_q[act_q] + DESC_W3_OFS;
                        mem_wdata_q <= own_clear;
                        state_q <= ST_WR_OWN;
                    end
                end
                ST_WR_OWN: begin
                    if (mem_done) begin
                        mem_we_q <= 1'b0;
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign mem_req = mem_req_q;
    assign mem_we = mem_we_q;
    assign mem_addr = mem_addr_q;
    assign mem_wdata = mem_wdata_q;
    assign fifo_beat = beat_q;
    assign fifo_valid = fifo_valid_q;
    assign fifo_chan = CH_FIELD_W'(act_q);
    assign tx_channel_irq = irq_q;
endmodule // utd_tx_dma
